/* fucc_pkg.sv */
// Package: constants and carrier types for the float unit config control block
`default_nettype none
package fucc_pkg;

  // Main control register field positions
  localparam int unsigned MCR_WIDTH    = 32;
  localparam int unsigned MCR_MON_BIT      = 1;
  localparam int unsigned MCR_EMU_BIT      = 2;
  localparam int unsigned MCR_SWITCH_BIT   = 3;
  localparam int unsigned MCR_NATIVE_BIT   = 5;
  localparam int unsigned MCR_NO_WT_BIT    = 29;
  localparam int unsigned MCR_NO_CACHE_BIT = 30;
  localparam logic [31:0] MCR_RESET    = 32'h6000_0010;

  // Extension control register field positions
  localparam int unsigned XCR_VSAVE_BIT = 9;
  localparam int unsigned XCR_VEXC_BIT  = 10;
  localparam logic [31:0] XCR_RESET     = 32'h0000_0000;

  // Identify instruction leaf and feature bit positions
  localparam logic [31:0] ID_LEAF_FEAT  = 32'h0000_0001;
  localparam int unsigned FEAT_FLUSH    = 19;
  localparam int unsigned FEAT_VSTATE   = 24;
  localparam int unsigned FEAT_VEC1     = 25;
  localparam int unsigned FEAT_VEC2     = 26;

  // Range memory type register layout
  localparam int unsigned MTR_WIDTH     = 8;
  localparam logic [7:0]  MTYPE_UNCACHED = 8'h00;

  // Instruction class presented by the decoder
  typedef enum logic [1:0] {
    FUCC_OP_NONE  = 2'b00,
    FUCC_OP_FLOAT = 2'b01,
    FUCC_OP_WAIT  = 2'b10,
    FUCC_OP_OTHER = 2'b11
  } fucc_op_t;

  // Outcome of an issued instruction
  typedef enum logic [1:0] {
    FUCC_ACT_IDLE = 2'b00,
    FUCC_ACT_EXEC = 2'b01,
    FUCC_ACT_TRAP = 2'b10
  } fucc_act_t;

  // Page-level caching bits from a directory or table entry
  typedef struct packed {
    logic page_cache_disable_bit;
    logic page_write_through_bit;
  } fucc_page_t;

  // Effective caching decision for an access
  typedef struct packed {
    logic cacheable;
    logic write_through;
  } fucc_cache_t;

endpackage
`default_nettype wire

/* fucc_dispatch.sv */
// Dispatch decision for float and wait instructions from the control flags
`default_nettype none
module fucc_dispatch (
  // Control flags
  input  wire logic              emulate_float_flag,
  input  wire logic              monitor_coproc_flag,
  input  wire logic              task_switched_flag,
  // Instruction class
  input  wire fucc_pkg::fucc_op_t op,
  // Decision
  output var fucc_pkg::fucc_act_t act
);

  // Emulation traps every float op; task switch traps lazily saved state
  always_comb begin
    act = fucc_pkg::FUCC_ACT_IDLE;
    case (op)
      fucc_pkg::FUCC_OP_FLOAT: begin
        if (emulate_float_flag) begin
          act = fucc_pkg::FUCC_ACT_TRAP;
        end else if (task_switched_flag) begin
          act = fucc_pkg::FUCC_ACT_TRAP;
        end else begin
          act = fucc_pkg::FUCC_ACT_EXEC;
        end
      end
      fucc_pkg::FUCC_OP_WAIT: begin
        if (monitor_coproc_flag && task_switched_flag) begin
          act = fucc_pkg::FUCC_ACT_TRAP;
        end else begin
          act = fucc_pkg::FUCC_ACT_EXEC;
        end
      end
      fucc_pkg::FUCC_OP_OTHER: act = fucc_pkg::FUCC_ACT_EXEC;
      default:                 act = fucc_pkg::FUCC_ACT_IDLE;
    endcase
  end

endmodule
`default_nettype wire

/* fucc_top.sv */
// Float unit configuration control: control registers, dispatch, identify, cache setup
// Summary of operation
// - Reset clears emulate, monitor-coprocessor and native-error flags.
// - Emulate set traps every float instruction; clear lets the unit execute unless task-switched is set.
// - Monitor flag clear: wait instructions ignore task-switched flag.
// - Monitor and task-switched both set: wait instruction traps.
// - Native-error set reports errors internally, else via external interrupt.
// - Reset sets cache-disable and not-write-through; caches on when both clear.
// - Reset invalidates every internal cache line.
// - Page cache-disable and write-through bits steer page caching.
// - Model registers readable and writable by dedicated instructions.
// - All-zero range register means uncached; reset clears them all.
// - Identify leaf 1 returns vector bits 25, 26 and save/restore bit 24.
// - Identify leaf 1 reports cache-line flush support in bit 19.
`default_nettype none
module fucc_top #(
  parameter int unsigned CACHE_LINES  = 64,
  parameter int unsigned MODEL_REGS   = 16,
  parameter int unsigned RANGE_REGS   = 8,
  parameter logic [31:0] FEAT_OTHERS  = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // Main and extension control register writes
  input  wire logic                      mcr_wr,
  input  wire logic [31:0]               mcr_wdata,
  input  wire logic                      xcr_wr,
  input  wire logic [31:0]               xcr_wdata,
  // Control register views
  output logic      [31:0]               main_control_register,
  output logic      [31:0]               extension_control_register,
  output logic                           os_vector_save_flag,
  output logic                           os_vector_except_flag,
  // Instruction issue
  input  wire logic                      issue,
  input  wire fucc_pkg::fucc_op_t        issue_op,
  output logic                           exec_go,
  output logic                           device_unavailable_trap,
  // Unmasked float exception reporting
  input  wire logic                      float_err,
  output logic                           float_err_internal,
  output logic                           float_err_external,
  // Identify instruction
  input  wire logic                      identify_instr,
  input  wire logic [31:0]               accumulator_register,
  output logic      [31:0]               feature_data_register,
  // Model register access
  input  wire logic                      model_reg_read_instr,
  input  wire logic                      model_reg_write_instr,
  input  wire logic [$clog2(MODEL_REGS)-1:0] model_idx,
  input  wire logic [31:0]               model_wdata,
  output logic      [31:0]               model_rdata,
  // Range memory type registers
  input  wire logic                      range_wr,
  input  wire logic [$clog2(RANGE_REGS)-1:0] range_idx,
  input  wire logic [7:0]                range_wdata,
  input  wire logic [$clog2(RANGE_REGS)-1:0] range_sel,
  output logic                           range_uncached,
  // Cache line fill and page caching
  input  wire logic                      line_fill,
  input  wire logic [$clog2(CACHE_LINES)-1:0] line_idx,
  output logic                           line_valid,
  input  wire fucc_pkg::fucc_page_t      page_bits,
  output var fucc_pkg::fucc_cache_t      cache_ctl,
  output logic                           caches_enabled
);

  // Index width of the range registers, used to size the loop compare
  localparam int unsigned RANGE_IW = $clog2(RANGE_REGS);

  logic [31:0]            mcr;
  logic [31:0]            next_mcr;
  logic [31:0]            xcr;
  logic [31:0]            next_xcr;
  logic [CACHE_LINES-1:0] valid;
  logic [CACHE_LINES-1:0] next_valid;
  logic [31:0]            model_mem [MODEL_REGS];
  logic [7:0]             range_mem [RANGE_REGS];
  logic                   emulate_float_flag;
  logic                   monitor_coproc_flag;
  logic                   native_error_flag;
  logic                   task_switched_flag;
  logic                   cache_disable_flag;
  logic                   not_write_through_flag;
  fucc_pkg::fucc_act_t    act;
  logic                   next_exec;
  logic                   next_trap;
  logic                   next_err_int;
  logic                   next_err_ext;
  logic [31:0]            next_feat;
  logic [31:0]            next_model_rdata;
  fucc_pkg::fucc_cache_t  next_cache_ctl;

  // Feature word built from the fixed capability bits
  function automatic logic [31:0] feat_word(input logic [31:0] others);
    logic [31:0] w;
    w = others;
    w[fucc_pkg::FEAT_VEC1]   = 1'b1;
    w[fucc_pkg::FEAT_VEC2]   = 1'b1;
    w[fucc_pkg::FEAT_VSTATE] = 1'b1;
    w[fucc_pkg::FEAT_FLUSH]  = 1'b1;
    return w;
  endfunction

  // Flag views of the main control register
  assign emulate_float_flag     = mcr[fucc_pkg::MCR_EMU_BIT];
  assign monitor_coproc_flag    = mcr[fucc_pkg::MCR_MON_BIT];
  assign native_error_flag      = mcr[fucc_pkg::MCR_NATIVE_BIT];
  assign task_switched_flag     = mcr[fucc_pkg::MCR_SWITCH_BIT];
  assign cache_disable_flag     = mcr[fucc_pkg::MCR_NO_CACHE_BIT];
  assign not_write_through_flag = mcr[fucc_pkg::MCR_NO_WT_BIT];

  // Instruction dispatch decision
  fucc_dispatch u_dispatch (
    .emulate_float_flag  (emulate_float_flag),
    .monitor_coproc_flag (monitor_coproc_flag),
    .task_switched_flag  (task_switched_flag),
    .op                  (issue ? issue_op : fucc_pkg::FUCC_OP_NONE),
    .act                 (act)
  );

  // Control register next values; extension bits are software-owned
  always_comb begin
    next_mcr = mcr;
    next_xcr = xcr;
    if (mcr_wr) begin
      next_mcr = mcr_wdata;
    end
    if (xcr_wr) begin
      next_xcr = xcr_wdata;
    end
  end

  // Cache line validity; fills only mark lines while caching is on
  always_comb begin
    next_valid = valid;
    if (line_fill && caches_enabled) begin
      next_valid[line_idx] = 1'b1;
    end
  end

  // Registered outputs for dispatch, errors, identify and caching
  always_comb begin
    next_exec    = (act == fucc_pkg::FUCC_ACT_EXEC);
    next_trap    = (act == fucc_pkg::FUCC_ACT_TRAP);
    next_err_int = float_err && native_error_flag;
    next_err_ext = float_err && !native_error_flag;
    next_feat    = feature_data_register;
    if (identify_instr) begin
      if (accumulator_register == fucc_pkg::ID_LEAF_FEAT) begin
        next_feat = feat_word(FEAT_OTHERS);
      end else begin
        next_feat = 32'h0000_0000;
      end
    end
    next_model_rdata = model_rdata;
    if (model_reg_read_instr) begin
      next_model_rdata = model_mem[model_idx];
    end
    // Page bits only refine caching; global disable wins
    next_cache_ctl.cacheable     = caches_enabled && !page_bits.page_cache_disable_bit;
    next_cache_ctl.write_through = page_bits.page_write_through_bit;
  end

  // Control state registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mcr   <= fucc_pkg::MCR_RESET;
      xcr   <= fucc_pkg::XCR_RESET;
      valid <= '0;
    end else begin
      mcr   <= next_mcr;
      xcr   <= next_xcr;
      valid <= next_valid;
    end
  end

  // Output registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      exec_go                 <= 1'b0;
      device_unavailable_trap <= 1'b0;
      float_err_internal      <= 1'b0;
      float_err_external      <= 1'b0;
      feature_data_register   <= 32'h0000_0000;
      model_rdata             <= 32'h0000_0000;
      cache_ctl               <= '0;
    end else begin
      exec_go                 <= next_exec;
      device_unavailable_trap <= next_trap;
      float_err_internal      <= next_err_int;
      float_err_external      <= next_err_ext;
      feature_data_register   <= next_feat;
      model_rdata             <= next_model_rdata;
      cache_ctl               <= next_cache_ctl;
    end
  end

  // Model register storage; contents undefined after reset
  always_ff @(posedge mclk) begin
    if (model_reg_write_instr) begin
      model_mem[model_idx] <= model_wdata;
    end
  end

  // Range registers cleared at reset so every range starts uncached
  generate
    for (genvar i = 0; i < RANGE_REGS; i++) begin : g_range
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          range_mem[i] <= fucc_pkg::MTYPE_UNCACHED;
        end else if (range_wr && (range_idx == RANGE_IW'(i))) begin
          range_mem[i] <= range_wdata;
        end
      end
    end
  endgenerate

  // Status views
  assign main_control_register      = mcr;
  assign extension_control_register = xcr;
  assign os_vector_save_flag        = xcr[fucc_pkg::XCR_VSAVE_BIT];
  assign os_vector_except_flag      = xcr[fucc_pkg::XCR_VEXC_BIT];
  assign caches_enabled             = !cache_disable_flag && !not_write_through_flag;
  assign range_uncached             = (range_mem[range_sel] == fucc_pkg::MTYPE_UNCACHED);
  assign line_valid                 = valid[line_idx];

endmodule
`default_nettype wire

/* fucc_top_asserts.sv */
// Concurrent checks on the float unit config control ports
`default_nettype none
module fucc_top_asserts (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // Control register view
  input wire logic [31:0]        main_control_register,
  // Issue and outcome
  input wire logic               issue,
  input wire fucc_pkg::fucc_op_t issue_op,
  input wire logic               exec_go,
  input wire logic               device_unavailable_trap,
  // Error routing
  input wire logic               float_err,
  input wire logic               float_err_internal,
  input wire logic               float_err_external,
  // Identify and caching
  input wire logic               identify_instr,
  input wire logic [31:0]        accumulator_register,
  input wire logic [31:0]        feature_data_register,
  input wire logic               caches_enabled
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Flag views, decisions use the value held when the op is taken
  logic emu_on, mon_on, switched, native;
  assign emu_on   = main_control_register[fucc_pkg::MCR_EMU_BIT];
  assign mon_on   = main_control_register[fucc_pkg::MCR_MON_BIT];
  assign switched = main_control_register[fucc_pkg::MCR_SWITCH_BIT];
  assign native   = main_control_register[fucc_pkg::MCR_NATIVE_BIT];
  sequence s_float; issue && issue_op == fucc_pkg::FUCC_OP_FLOAT; endsequence
  sequence s_wait; issue && issue_op == fucc_pkg::FUCC_OP_WAIT; endsequence
  sequence s_trap; device_unavailable_trap && !exec_go; endsequence
  sequence s_exec; exec_go && !device_unavailable_trap; endsequence
  a_reset_flags:
    assert property (!$past(rst_n) |-> main_control_register == fucc_pkg::MCR_RESET)
    else $error("control register not at reset value");
  a_emul_trap:
    assert property (s_float ##0 emu_on |=> s_trap) else $error("float not trapped");
  a_float_exec:
    assert property (s_float ##0 !emu_on && !switched |=> s_exec) else $error("float not run");
  a_switch_trap:
    assert property (s_float ##0 switched |=> s_trap) else $error("float ran while switched");
  a_wait_free:
    assert property (s_wait ##0 !mon_on |=> s_exec) else $error("wait did not complete");
  a_wait_trap:
    assert property (s_wait ##0 mon_on && switched |=> s_trap) else $error("wait not trapped");
  a_err_route:
    assert property (float_err |=> float_err_internal == $past(native)
                     && float_err_external == !$past(native)) else $error("error misrouted");
  a_ident_bits:
    assert property (identify_instr && accumulator_register == 32'h0000_0001
                     |=> (feature_data_register & 32'h0708_0000) == 32'h0708_0000)
    else $error("feature bits missing");
  a_cache_gate:
    assert property (caches_enabled == (!main_control_register[30] && !main_control_register[29]))
    else $error("cache enable mismatch");
endmodule
bind fucc_top fucc_top_asserts u_asserts (.mclk, .rst_n, .main_control_register, .issue,
  .issue_op, .exec_go, .device_unavailable_trap, .float_err, .float_err_internal,
  .float_err_external, .identify_instr, .accumulator_register, .feature_data_register,
  .caches_enabled);
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the float unit config control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, mcr_wr, xcr_wr, issue, float_err, identify_instr, range_wr;
  logic model_reg_read_instr, model_reg_write_instr, line_fill, line_valid, range_uncached;
  logic exec_go, device_unavailable_trap, float_err_internal, float_err_external;
  logic os_vector_save_flag, os_vector_except_flag, caches_enabled;
  logic [31:0] mcr_wdata, xcr_wdata, accumulator_register, model_wdata, model_rdata, m, d;
  logic [31:0] main_control_register, extension_control_register, feature_data_register;
  logic [3:0]  model_idx;
  logic [2:0]  range_idx, range_sel;
  logic [7:0]  range_wdata;
  logic [5:0]  line_idx;
  fucc_pkg::fucc_op_t   issue_op;
  fucc_pkg::fucc_page_t page_bits;
  fucc_pkg::fucc_cache_t cache_ctl;
  int failures, n_checks, cyc;
  fucc_top DUT (.mclk, .rst_n, .mcr_wr, .mcr_wdata, .xcr_wr, .xcr_wdata, .main_control_register,
    .extension_control_register, .os_vector_save_flag, .os_vector_except_flag, .issue,
    .issue_op, .exec_go, .device_unavailable_trap, .float_err, .float_err_internal,
    .float_err_external, .identify_instr, .accumulator_register, .feature_data_register,
    .model_reg_read_instr, .model_reg_write_instr, .model_idx, .model_wdata, .model_rdata,
    .range_wr, .range_idx, .range_wdata, .range_sel, .range_uncached, .line_fill, .line_idx,
    .line_valid, .page_bits, .cache_ctl, .caches_enabled);
  // Free-running 50 MHz clock
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard, far above the roughly 430 cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("wrong value at %0t: run did not finish", $time);
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Expected {trap, exec} from the flags held when the op is taken
  function automatic logic [1:0] exp_act(input logic [1:0] op, input logic [31:0] r);
    if (op == 2'b00) return 2'b00; // No instruction, no outcome
    if (op == 2'b11) return 2'b01; // Plain instruction always runs
    if (op == 2'b01) return (r[2] | r[3]) ? 2'b10 : 2'b01;
    return (r[1] & r[3]) ? 2'b10 : 2'b01;
  endfunction
  // Strobes drop one cycle after they rise; only raised ones are touched
  task automatic step;
    @(negedge mclk);
    if (mcr_wr) mcr_wr = 1'b0;
    if (xcr_wr) xcr_wr = 1'b0;
    if (issue) issue = 1'b0;
    if (float_err) float_err = 1'b0;
    if (identify_instr) identify_instr = 1'b0;
    if (range_wr) range_wr = 1'b0;
    if (model_reg_read_instr) model_reg_read_instr = 1'b0;
    if (model_reg_write_instr) model_reg_write_instr = 1'b0;
    if (line_fill) line_fill = 1'b0;
  endtask
  initial begin
    {rst_n, mcr_wr, xcr_wr, issue, float_err, identify_instr, range_wr} = '0;
    {model_reg_read_instr, model_reg_write_instr, line_fill} = '0;
    {mcr_wdata, xcr_wdata, accumulator_register, model_wdata, model_idx} = '0;
    {range_idx, range_sel, range_wdata, line_idx} = '0;
    issue_op = fucc_pkg::FUCC_OP_NONE;
    page_bits = '0;
    void'($urandom(32'h388e11e8));
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1;
    chk(main_control_register, 32'h6000_0010, "reset mcr");
    chk(extension_control_register, 32'h0, "reset xcr");
    for (int i = 0; i < 8; i++) begin
      range_sel = i[2:0];
      #1 chk(range_uncached, 1'b1, "reset range");
    end
    line_fill = 1; line_idx = 6'h05; step(); // Ignored while caches are off
    chk(line_valid, 1'b0, "fill while disabled");
    // First pass is the emulation setting, then random flag mixes
    for (int i = 0; i < 200; i++) begin
      m = (i == 0) ? 32'h6000_0034 : 32'h6000_0010 | ($urandom & 32'h0000_002e);
      mcr_wr = 1; mcr_wdata = m; step();
      chk(main_control_register, m, "mcr write");
      chk({device_unavailable_trap, exec_go}, 2'b00, "pulse dropped");
      issue = 1; issue_op = fucc_pkg::fucc_op_t'((i == 0) ? 2'b01 : 2'($urandom));
      float_err = 1'($urandom);
      d = {28'h0, float_err & m[fucc_pkg::MCR_NATIVE_BIT],
           float_err & !m[fucc_pkg::MCR_NATIVE_BIT], exp_act(issue_op, m)};
      step();
      chk({device_unavailable_trap, exec_go}, d[1:0], "dispatch");
      chk({float_err_internal, float_err_external}, d[3:2], "error path");
    end
    identify_instr = 1; accumulator_register = 32'h1; step();
    chk(feature_data_register, 32'h0708_0000, "feature leaf");
    @(negedge mclk);
    chk(feature_data_register, 32'h0708_0000, "feature held");
    identify_instr = 1; accumulator_register = $urandom | 32'h2; step();
    chk(feature_data_register, 32'h0, "other leaf");
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      model_reg_write_instr = 1; model_idx = 4'(i * 5); model_wdata = d; step();
      model_reg_read_instr = 1; step();
      chk(model_rdata, d, "model readback");
    end
    range_wr = 1; range_idx = 3'h3; range_wdata = 8'h06; step();
    range_sel = 3'h3;
    #1 chk(range_uncached, 1'b0, "range typed");
    range_wr = 1; range_wdata = 8'h00; step();
    chk(range_uncached, 1'b1, "range cleared");
    xcr_wr = 1; xcr_wdata = 32'h0000_0600; step();
    chk({os_vector_save_flag, os_vector_except_flag}, 2'b11, "os flags");
    mcr_wr = 1; mcr_wdata = 32'h0000_0012; step();
    chk(caches_enabled, 1'b1, "caches on");
    chk(main_control_register, 32'h0000_0012, "float unit setting");
    issue = 1; issue_op = fucc_pkg::FUCC_OP_WAIT; step();
    chk({device_unavailable_trap, exec_go}, 2'b01, "wait with monitor on");
    line_fill = 1; step();
    chk(line_valid, 1'b1, "fill enabled");
    line_idx = 6'h06;
    #1 chk(line_valid, 1'b0, "other line");
    for (int i = 0; i < 4; i++) begin
      page_bits = i[1:0]; step();
      chk(cache_ctl, {!i[1], i[0]}, "page caching");
    end
    rst_n = 0; line_idx = 6'h05; step();
    rst_n = 1;
    chk(main_control_register, 32'h6000_0010, "second reset");
    chk(extension_control_register, 32'h0, "second reset xcr");
    chk(caches_enabled, 1'b0, "caches off again");
    chk(line_valid, 1'b0, "lines invalid again");
    close_out();
  end
endmodule
`default_nettype wire
